// >>> verif/test_udpec_top.sv
// self-checking bench for the port and endpoint control block
// assumes the host model supplies tokens, success reports and line levels
`timescale 1ns/100ps
`include "udpec_params.svh"
`default_nettype none

module test_udpec_top
    import udpec_pkg::*;
;
    localparam logic [20:0] FULL = 21'h1FFFFF;
    localparam logic [20:0] HSM = 21'h1E0000;
    localparam logic [20:0] OUTM = 21'h1F00FF;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic se_rst = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [7:0] ep23 = 8'h00;
    logic [7:0] rdata;
    logic [7:0] mode;
    logic pd, slow, pen, dp, dm;
    udpec_event_t tok, done;
    udpec_answer_t ans;
    logic [31:0] seed = 32'h0000A1DD; // 41437
    logic [7:0] ctl [5] = '{`UDPEC_BASE_EP0, `UDPEC_BASE_EP1, `UDPEC_BASE_EP2, `UDPEC_BASE_EP3, `UDPEC_BASE_EP4};
    logic [7:0] lens [5];
    udpec_hs_t ohs [4] = '{UDPEC_HS_ACK, UDPEC_HS_NONE, UDPEC_HS_NAK, UDPEC_HS_STALL};
    udpec_hs_t ihs [4] = '{UDPEC_HS_DATA, UDPEC_HS_DATA_NOWAIT, UDPEC_HS_NAK, UDPEC_HS_STALL};
    logic [7:0] exp_rd [$];
    udpec_answer_t exp_ans [$];
    logic [20:0] exp_msk [$];
    logic rd_seen = 1'b0;
    logic ans_seen = 1'b0;
    int error_cnt = 0;
    int n_compared = 0;

    always #5 mclk = ~mclk;

    udpec_top #(.EP_NUM(5)) DUT (
        .MCLK_I(mclk), .SRST_I(srst), .SERIAL_ENGINE_RESET_I(se_rst),
        .PLUS_DATA_PIN_I(dp), .MINUS_DATA_PIN_I(dm), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
        .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .EP23_MODE_I(ep23), .TOKEN_I(tok),
        .DONE_I(done), .ANSWER_O(ans), .PULLDOWN_DIS_O(pd), .SLOW_RATE_O(slow),
        .PHYS_PORT_EN_O(pen), .EP14_MODE_O(mode)
    );
    udpec_host_model u_host (.clk_i(mclk), .token_o(tok), .done_o(done), .plus_o(dp), .minus_o(dm));

    // ****************
    // helpers
    // ****************
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic udpec_answer_t mk(udpec_hs_t h, logic p, logic [7:0] l, logic [7:0] b);
        return {1'b1, h, p, l, b};
    endfunction

    task automatic check(input logic [20:0] seen, input logic [20:0] exp, input logic [20:0] msk);
        n_compared++;
        if ((seen & msk) !== (exp & msk))
        begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    task automatic rreg(input logic [7:0] a, input logic [7:0] e);
        exp_rd.push_back(e);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
    endtask

    task automatic tk(input logic is_in, input logic [2:0] ep, input udpec_answer_t e, input logic [20:0] m);
        exp_ans.push_back(e);
        exp_msk.push_back(m);
        seed = xs(seed);
        u_host.send(1'b0, is_in, ep, int'(seed[1:0]));
    endtask

    task automatic give_verdict();
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
        begin
            $display("DONE - PASS");
        end
        else
        begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ****************
    // output monitor
    // ****************
    always @(posedge mclk)
    begin
        rd_seen <= rd;
        ans_seen <= tok.valid;
    end

    // negedge sampling keeps clear of the launching edge
    always @(negedge mclk)
    begin
        if (rd_seen)
            check({13'h0, rdata}, {13'h0, exp_rd.pop_front()}, 21'hFF);
        if (ans_seen)
            check(ans, exp_ans.pop_front(), exp_msk.pop_front());
    end

    initial
    begin
        repeat (5000) @(posedge mclk);
        error_cnt++;
        give_verdict();
    end

    // ****************
    // scenarios
    // ****************
    initial
    begin
        repeat (5) @(posedge mclk);
        srst <= 1'b0;
        repeat (3) @(posedge mclk);
        rreg(`UDPEC_ADDR_PORT, 8'hA0);
        for (int i = 0; i < 5; i++)
            rreg(ctl[i], 8'h00);
        rreg(`UDPEC_BASE_EP2 + 8'h01, 8'h00);
        rreg(`UDPEC_ADDR_MODE, 8'h00);
        rreg(8'h00, 8'h00);
        tk(1'b0, 3'h0, mk(UDPEC_HS_NONE, 1'b0, 8'h00, 8'h00), HSM);
        $display("reset values done");
        wreg(`UDPEC_ADDR_PORT, 8'hFF);
        rreg(`UDPEC_ADDR_PORT, 8'hA7);
        for (int i = 0; i < 4; i++)
        begin
            seed = xs(seed);
            u_host.lines(seed[0], seed[1]);
            repeat (3) @(posedge mclk);
            rreg(`UDPEC_ADDR_PORT, {2'h2, seed[0], seed[1], 4'h7});
        end
        u_host.lines(1'b1, 1'b0);
        wreg(`UDPEC_ADDR_PORT, 8'h07);
        rreg(`UDPEC_ADDR_PORT, 8'h27);
        @(posedge mclk);
        se_rst <= 1'b1;
        @(posedge mclk);
        se_rst <= 1'b0;
        rreg(`UDPEC_ADDR_PORT, 8'hA0);
        $display("port control done");
        for (int i = 0; i < 5; i++)
        begin
            seed = xs(seed);
            lens[i] = seed[7:0];
            wreg(ctl[i] + 8'h01, lens[i]);
            rreg(ctl[i] + 8'h01, lens[i]);
        end
        wreg(`UDPEC_ADDR_PORT, 8'h81);
        for (int c = 0; c < 4; c++)
        begin
            wreg(ctl[0], {4'hC, c[1:0], c[1:0]});
            tk(1'b0, 3'h0, mk(ohs[c], 1'b1, lens[0], 8'h00), OUTM);
            tk(1'b1, 3'h0, mk(ihs[c], 1'b1, lens[0], 8'h00), FULL);
        end
        wreg(ctl[0], 8'hFF);
        rreg(ctl[0], 8'hDF);
        $display("responses done");
        wreg(`UDPEC_ADDR_MODE, 8'hD0);
        rreg(`UDPEC_ADDR_MODE, 8'hD0);
        wreg(ctl[1], 8'h10);
        u_host.send(1'b1, 1'b0, 3'h1, 0);
        rreg(ctl[1], 8'h90);
        u_host.send(1'b1, 1'b1, 3'h1, 1);
        rreg(ctl[1], 8'hD0);
        tk(1'b0, 3'h1, mk(UDPEC_HS_ACK, 1'b1, lens[1], 8'h40), OUTM);
        tk(1'b1, 3'h1, mk(UDPEC_HS_DATA, 1'b1, lens[1], 8'hC0), FULL);
        wreg(ctl[1], 8'h00);
        u_host.send(1'b1, 1'b0, 3'h1, 0);
        rreg(ctl[1], 8'h00);
        for (int e = 0; e < 5; e += 4)
        begin
            wreg(ctl[e], 8'h10);
            u_host.send(1'b1, 1'b0, e[2:0], 0);
            u_host.send(1'b1, 1'b1, e[2:0], 2);
            rreg(ctl[e], 8'h10);
        end
        $display("toggles done");
        wreg(`UDPEC_ADDR_MODE, 8'hFF);
        rreg(`UDPEC_ADDR_MODE, 8'hDC);
        wreg(`UDPEC_ADDR_MODE, 8'h0C);
        wreg(ctl[4], 8'h00);
        tk(1'b0, 3'h4, mk(UDPEC_HS_ACK, 1'b0, lens[4], 8'h40), OUTM);
        tk(1'b1, 3'h4, mk(UDPEC_HS_DATA, 1'b0, lens[4], 8'h80), FULL);
        wreg(`UDPEC_ADDR_MODE, 8'h04);
        tk(1'b1, 3'h4, mk(UDPEC_HS_DATA, 1'b0, lens[4], 8'h40), FULL);
        $display("endpoint 4 layout done");
        ep23 <= 8'h0C;
        wreg(ctl[2], 8'h0A);
        tk(1'b1, 3'h2, mk(UDPEC_HS_NAK, 1'b0, lens[2], 8'h40), FULL);
        tk(1'b0, 3'h2, mk(UDPEC_HS_NAK, 1'b0, lens[2], 8'h00), FULL);
        tk(1'b1, 3'h3, mk(UDPEC_HS_NONE, 1'b0, lens[3], 8'h00), FULL);
        repeat (3) @(posedge mclk);
        $display("endpoint 2 and 3 done");
        give_verdict();
    end
endmodule
`default_nettype wire

// >>> verif/udpec_host_model.sv
// bus-side partner: token and success reports plus data line levels
// assumes the caller is a procedural bench on the same clock
`timescale 1ns/100ps
`default_nettype none

module udpec_host_model
    import udpec_pkg::*;
(
    input wire logic clk_i,
    output var udpec_event_t token_o,
    output var udpec_event_t done_o,
    output logic plus_o,
    output logic minus_o
);
    // idle full-speed line state until told otherwise
    initial
    begin
        token_o = '0;
        done_o = '0;
        plus_o = 1'b1;
        minus_o = 1'b0;
    end

    // gap lets the host answer promptly or slowly
    task automatic send(input logic is_done, input logic is_in, input logic [2:0] ep, input int gap);
        repeat (gap) @(posedge clk_i);
        @(posedge clk_i);
        if (is_done)
            done_o <= {1'b1, is_in, ep};
        else
            token_o <= {1'b1, is_in, ep};
        @(posedge clk_i);
        done_o <= '0;
        token_o <= '0;
    endtask

    task automatic lines(input logic p, input logic m);
        @(posedge clk_i);
        plus_o <= p;
        minus_o <= m;
    endtask
endmodule
`default_nettype wire

// >>> verif/udpec_top_asserts.sv
// concurrent checks on the port control and endpoint answer outputs
// assumes one clock domain and a synchronous active-high system reset
`timescale 1ns/100ps
`include "udpec_params.svh"
`default_nettype none

module udpec_top_asserts
    import udpec_pkg::*;
#(
    parameter int EP_NUM = 5
)
(
    input wire logic MCLK_I,
    input wire logic SRST_I,
    input wire logic SERIAL_ENGINE_RESET_I,
    input wire logic [7:0] REG_ADDR_I,
    input wire logic [7:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    input wire logic [7:0] REG_RDATA_O,
    input wire udpec_event_t TOKEN_I,
    input wire udpec_answer_t ANSWER_O,
    input wire logic PULLDOWN_DIS_O,
    input wire logic SLOW_RATE_O,
    input wire logic PHYS_PORT_EN_O,
    input wire logic [7:0] EP14_MODE_O
);
    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (SRST_I);

    // ****************
    // register side
    // ****************
    a_port_write: assert property (
        REG_WR_I && REG_ADDR_I == `UDPEC_ADDR_PORT && !SERIAL_ENGINE_RESET_I
        |=> {PULLDOWN_DIS_O, 4'h0, SLOW_RATE_O, 1'b0, PHYS_PORT_EN_O} == ($past(REG_WDATA_I) & 8'h85))
        else $error("port outputs do not follow write");
    a_se_reset: assert property (
        SERIAL_ENGINE_RESET_I |=> PULLDOWN_DIS_O && !SLOW_RATE_O && !PHYS_PORT_EN_O)
        else $error("engine reset left port bits");
    a_mode_write: assert property (
        REG_WR_I && REG_ADDR_I == `UDPEC_ADDR_MODE |=> EP14_MODE_O == ($past(REG_WDATA_I) & 8'hDC))
        else $error("mode register write wrong");
    a_mode_hold: assert property (
        !(REG_WR_I && REG_ADDR_I == `UDPEC_ADDR_MODE) |=> $stable(EP14_MODE_O))
        else $error("mode register changed unasked");
    a_rd_rsvd: assert property (
        REG_RD_I && REG_ADDR_I == `UDPEC_ADDR_PORT |=> (REG_RDATA_O & 8'h48) == 8'h00)
        else $error("port reserved bits not zero");
    a_rd_idle: assert property (
        !REG_RD_I |=> REG_RDATA_O == 8'h00)
        else $error("read data outside its cycle");

    // ****************
    // token answers
    // ****************
    a_ans_timing: assert property (
        TOKEN_I.valid |=> ANSWER_O.valid ##1 (ANSWER_O == '0 || $past(TOKEN_I.valid)))
        else $error("answer timing wrong");
    a_port_off: assert property (
        TOKEN_I.valid && !PHYS_PORT_EN_O |=> ANSWER_O.hs == UDPEC_HS_NONE)
        else $error("answer while port disabled");
    a_ep4_layout: assert property (
        TOKEN_I.valid && TOKEN_I.is_in && TOKEN_I.ep == 3'h4 && EP14_MODE_O[3:2] == 2'h3
        |=> ANSWER_O.buf_off == 8'h80)
        else $error("endpoint 4 transmit offset wrong");
    a_ep0_base: assert property (
        TOKEN_I.valid && TOKEN_I.ep == 3'h0 |=> ANSWER_O.buf_off == 8'h00)
        else $error("endpoint 0 offset wrong");

    c_se_reset: cover property (SERIAL_ENGINE_RESET_I);
    c_in_token: cover property (TOKEN_I.valid && TOKEN_I.is_in && PHYS_PORT_EN_O);
    c_mode_wr: cover property (REG_WR_I && REG_ADDR_I == `UDPEC_ADDR_MODE);
endmodule

bind udpec_top udpec_top_asserts #(.EP_NUM(EP_NUM)) u_chk (
    .MCLK_I(MCLK_I), .SRST_I(SRST_I), .SERIAL_ENGINE_RESET_I(SERIAL_ENGINE_RESET_I),
    .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
    .REG_RDATA_O(REG_RDATA_O), .TOKEN_I(TOKEN_I), .ANSWER_O(ANSWER_O), .PULLDOWN_DIS_O(PULLDOWN_DIS_O),
    .SLOW_RATE_O(SLOW_RATE_O), .PHYS_PORT_EN_O(PHYS_PORT_EN_O), .EP14_MODE_O(EP14_MODE_O)
);
`default_nettype wire

// >>> verilog/udpec_params.svh
// constants for the usb device port and endpoint control block
// assumes an 8-bit register port and a same-clock serial engine beside it
// Function
// R1 - port bit 7 disables data-pin pull-downs; resets to 1; works in gpio use
// R2 - port bits 5 and 4 read live plus and minus line levels
// R3 - port bit 2 selects low speed when 1, full speed when 0; resets 0
// R4 - port bit 1 is a software-only flag, no hardware effect, resets 0
// R5 - port bit 0 enables the physical port; resets 0
// R6 - serial engine reset also returns the port register to reset values
// R7 - endpoint bit 7 is the expected receive toggle, resets 0
// R8 - endpoint bit 6 is the data pid sent on in, resets 0
// R9 - endpoint bit 4 flips the relevant toggle after each successful transfer
// R10 - without auto flip only software changes toggles; auto only endpoints 1-3
// R11 - receive response bits 3:2, transmit response bits 1:0, all reset 0
// R12 - receive response 00 ack, 10 nak, 11 stall
// R13 - receive response 01 sends no handshake
// R14 - transmit response 00 data expecting ack, 10 nak, 11 stall
// R15 - transmit response 01 sends data without awaiting handshake
// R16 - each endpoint has an 8-bit transmit byte count for the next in
// R17 - endpoint 2 transmit length resets to zero
// R18 - mode bit 7 enables endpoint 1 out, bit 6 endpoint 1 in; reset off
// R19 - mode bit 4 selects endpoint 1 buffer mode, resets 0
// R20 - mode bit 3 enables endpoint 4 out, bit 2 endpoint 4 in; reset 0
// R21 - endpoint 0/4 buffer layout follows only endpoint 4 enable bits
// R22 - both endpoint 4 enables: ep0 at base, ep4 rx +64, tx +128
// R23 - double buffer: first 64 bytes for toggle 0, second for toggle 1
// R24 - reserved bits read zero and ignore writes
`ifndef UDPEC_PARAMS_SVH
`define UDPEC_PARAMS_SVH
`define UDPEC_ADDR_PORT 8'hD1
`define UDPEC_ADDR_MODE 8'hEA
`define UDPEC_BASE_EP0 8'hDC
`define UDPEC_BASE_EP1 8'hD2
`define UDPEC_BASE_EP2 8'hD4
`define UDPEC_BASE_EP3 8'hD6
`define UDPEC_BASE_EP4 8'hDE
`define UDPEC_LEN_BIT 0
`define UDPEC_PORT_PD_DIS 7
`define UDPEC_PORT_DP 5
`define UDPEC_PORT_DM 4
`define UDPEC_PORT_LOW 2
`define UDPEC_PORT_FLAG 1
`define UDPEC_PORT_EN 0
`define UDPEC_CTL_RTOG 7
`define UDPEC_CTL_TTOG 6
`define UDPEC_CTL_AUTO 4
`define UDPEC_CTL_RRES_HI 3
`define UDPEC_CTL_RRES_LO 2
`define UDPEC_CTL_TRES_HI 1
`define UDPEC_CTL_TRES_LO 0
`define UDPEC_CTL_WMASK 8'hDF
`define UDPEC_MODE_WMASK 8'hDC
`define UDPEC_MODE_EP1_RX 7
`define UDPEC_MODE_EP1_TX 6
`define UDPEC_MODE_EP1_BUF 4
`define UDPEC_MODE_EP4_RX 3
`define UDPEC_MODE_EP4_TX 2
`define UDPEC_M23_EP3_RX 7
`define UDPEC_M23_EP3_TX 6
`define UDPEC_M23_EP3_BUF 4
`define UDPEC_M23_EP2_RX 3
`define UDPEC_M23_EP2_TX 2
`define UDPEC_M23_EP2_BUF 0
`define UDPEC_RES_OK 2'h0
`define UDPEC_RES_QUIET 2'h1
`define UDPEC_RES_NAK 2'h2
`define UDPEC_RES_STALL 2'h3
`define UDPEC_RST_PD_DIS 1'b1
`define UDPEC_RST_BYTE 8'h00
`define UDPEC_BUF_STEP 8'h40
`define UDPEC_BUF_STEP2 8'h80
`define UDPEC_AUTO_EP_LO 1
`define UDPEC_AUTO_EP_HI 3
`define UDPEC_EP_NONE 3'h7
`endif

// >>> verilog/udpec_pkg.sv
// types shared by the usb device port and endpoint control block
// assumes endpoint numbers fit in three bits
package udpec_pkg;

    typedef enum logic [2:0] {
        UDPEC_HS_NONE,
        UDPEC_HS_ACK,
        UDPEC_HS_NAK,
        UDPEC_HS_STALL,
        UDPEC_HS_DATA,
        UDPEC_HS_DATA_NOWAIT
    } udpec_hs_t;

    // token arrival or successful transfer report from the serial engine
    typedef struct packed {
        logic valid;
        logic is_in;
        logic [2:0] ep;
    } udpec_event_t;

    typedef struct packed {
        logic valid;
        udpec_hs_t hs;
        logic pid_odd;
        logic [7:0] len;
        logic [7:0] buf_off;
    } udpec_answer_t;

endpackage

// >>> verilog/udpec_top.sv
// usb device port control, endpoint toggles, responses and lengths
// assumes the serial engine shares MCLK_I and reports tokens and successes
`timescale 1ns/100ps
`include "udpec_params.svh"
`default_nettype none

module udpec_top
    import udpec_pkg::*;
#(
    parameter int EP_NUM = 5
)
(
    input wire logic MCLK_I,
    input wire logic SRST_I,
    input wire logic SERIAL_ENGINE_RESET_I,
    input wire logic PLUS_DATA_PIN_I,
    input wire logic MINUS_DATA_PIN_I,
    input wire logic [7:0] REG_ADDR_I,
    input wire logic [7:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    output logic [7:0] REG_RDATA_O,
    input wire logic [7:0] EP23_MODE_I,
    input wire udpec_event_t TOKEN_I,
    input wire udpec_event_t DONE_I,
    output udpec_answer_t ANSWER_O,
    output logic PULLDOWN_DIS_O,
    output logic SLOW_RATE_O,
    output logic PHYS_PORT_EN_O,
    output logic [7:0] EP14_MODE_O
);

    // ****************************************************
    // decoding helpers
    // ****************************************************

    // register pair base (control even, length odd) to endpoint number
    function automatic logic [2:0] ep_of(input logic [7:0] addr);
        logic [7:0] base;
        base = {addr[7:1], 1'b0};
        case (base)
            `UDPEC_BASE_EP0: ep_of = 3'h0;
            `UDPEC_BASE_EP1: ep_of = 3'h1;
            `UDPEC_BASE_EP2: ep_of = 3'h2;
            `UDPEC_BASE_EP3: ep_of = 3'h3;
            `UDPEC_BASE_EP4: ep_of = 3'h4;
            default: ep_of = `UDPEC_EP_NONE;
        endcase
    endfunction

    // response field to handshake; code 01 is honoured on any endpoint
    function automatic udpec_hs_t hs_of(input logic is_in, input logic [1:0] code);
        udpec_hs_t hs;
        hs = UDPEC_HS_NONE;
        case (code)
            `UDPEC_RES_OK:
            begin
                hs = is_in ? UDPEC_HS_DATA : UDPEC_HS_ACK; // R12 R14
            end
            `UDPEC_RES_QUIET:
            begin
                hs = is_in ? UDPEC_HS_DATA_NOWAIT : UDPEC_HS_NONE; // R13 R15
            end
            `UDPEC_RES_NAK:
            begin
                hs = UDPEC_HS_NAK; // R12 R14
            end
            `UDPEC_RES_STALL:
            begin
                hs = UDPEC_HS_STALL; // R12 R14
            end
            default:
            begin
                hs = UDPEC_HS_NONE;
            end
        endcase
        return hs;
    endfunction

    // buffer offset for endpoints 1 to 3
    function automatic logic [7:0] buf_off_of(
        input logic rx_en,
        input logic tx_en,
        input logic dbl,
        input logic is_in,
        input logic tog
    );
        logic [7:0] off;
        off = `UDPEC_RST_BYTE;
        if (!is_in)
        begin
            off = (dbl && tog) ? `UDPEC_BUF_STEP : `UDPEC_RST_BYTE; // R23
        end
        else if (dbl)
        begin
            off = rx_en ? `UDPEC_BUF_STEP2 : `UDPEC_RST_BYTE;
            if (tog)
            begin
                off = off + `UDPEC_BUF_STEP; // R23
            end
        end
        else
        begin
            off = rx_en ? `UDPEC_BUF_STEP : `UDPEC_RST_BYTE;
        end
        if (!(is_in ? tx_en : rx_en))
        begin
            off = `UDPEC_RST_BYTE;
        end
        return off;
    endfunction

    // ****************************************************
    // line level synchronisers
    // ****************************************************

    logic dp_meta_r;
    logic dp_sync_r;
    logic dm_meta_r;
    logic dm_sync_r;

    always_ff @(posedge MCLK_I)
    begin
        if (SRST_I)
        begin
            dp_meta_r <= 1'b0;
            dp_sync_r <= 1'b0;
            dm_meta_r <= 1'b0;
            dm_sync_r <= 1'b0;
        end
        else
        begin
            dp_meta_r <= PLUS_DATA_PIN_I;
            dp_sync_r <= dp_meta_r; // R2
            dm_meta_r <= MINUS_DATA_PIN_I;
            dm_sync_r <= dm_meta_r; // R2
        end
    end

    // ****************************************************
    // register port decode
    // ****************************************************

    logic [2:0] wr_ep;
    logic wr_port;
    logic wr_mode;
    logic wr_ctl_any;
    logic wr_len_any;

    always_comb
    begin
        wr_ep = ep_of(REG_ADDR_I);
        wr_port = REG_WR_I && (REG_ADDR_I == `UDPEC_ADDR_PORT);
        wr_mode = REG_WR_I && (REG_ADDR_I == `UDPEC_ADDR_MODE);
        wr_ctl_any = REG_WR_I && (wr_ep != `UDPEC_EP_NONE) && !REG_ADDR_I[`UDPEC_LEN_BIT];
        wr_len_any = REG_WR_I && (wr_ep != `UDPEC_EP_NONE) && REG_ADDR_I[`UDPEC_LEN_BIT];
    end

    // ****************************************************
    // port control register
    // ****************************************************

    logic pd_dis_r;
    logic slow_r;
    logic user_flag_r;
    logic port_en_r;

    // engine reset must return these to their reset values too, not only the system reset
    always_ff @(posedge MCLK_I)
    begin
        if (SRST_I || SERIAL_ENGINE_RESET_I) // R6
        begin
            pd_dis_r <= `UDPEC_RST_PD_DIS; // R1
            slow_r <= 1'b0; // R3
            user_flag_r <= 1'b0; // R4
            port_en_r <= 1'b0; // R5
        end
        else if (wr_port)
        begin
            pd_dis_r <= REG_WDATA_I[`UDPEC_PORT_PD_DIS]; // R1
            slow_r <= REG_WDATA_I[`UDPEC_PORT_LOW]; // R3
            user_flag_r <= REG_WDATA_I[`UDPEC_PORT_FLAG]; // R4
            port_en_r <= REG_WDATA_I[`UDPEC_PORT_EN]; // R5
        end
    end

    // ****************************************************
    // endpoint 1/4 mode register
    // ****************************************************

    logic [7:0] mode_r;

    always_ff @(posedge MCLK_I)
    begin
        if (SRST_I)
        begin
            mode_r <= `UDPEC_RST_BYTE; // R18 R19 R20
        end
        else if (wr_mode)
        begin
            mode_r <= REG_WDATA_I & `UDPEC_MODE_WMASK; // R24
        end
    end

    // ****************************************************
    // endpoint control and length registers
    // ****************************************************

    logic [7:0] ctl_r [EP_NUM];
    logic [7:0] ctl_nxt [EP_NUM];
    logic [7:0] len_r [EP_NUM];

    genvar e;
    generate
        for (e = 0; e < EP_NUM; e++)
        begin : g_ep
            logic flip;

            // toggles flip on top of a same-cycle write so no success is lost
            always_comb
            begin
                flip = DONE_I.valid && (DONE_I.ep == 3'(e))
                    && ctl_r[e][`UDPEC_CTL_AUTO]
                    && (e >= `UDPEC_AUTO_EP_LO) && (e <= `UDPEC_AUTO_EP_HI); // R9 R10
                ctl_nxt[e] = (wr_ctl_any && wr_ep == 3'(e)) ? (REG_WDATA_I & `UDPEC_CTL_WMASK) : ctl_r[e]; // R24
                if (flip && DONE_I.is_in)
                begin
                    ctl_nxt[e][`UDPEC_CTL_TTOG] = ~ctl_nxt[e][`UDPEC_CTL_TTOG]; // R9
                end
                else if (flip)
                begin
                    ctl_nxt[e][`UDPEC_CTL_RTOG] = ~ctl_nxt[e][`UDPEC_CTL_RTOG]; // R9
                end
            end

            always_ff @(posedge MCLK_I)
            begin
                if (SRST_I)
                begin
                    ctl_r[e] <= `UDPEC_RST_BYTE; // R7 R8 R11
                end
                else
                begin
                    ctl_r[e] <= ctl_nxt[e]; // R10
                end
            end

            // only endpoint 2 must come up zero; the rest are cleared too
            always_ff @(posedge MCLK_I)
            begin
                if (SRST_I)
                begin
                    len_r[e] <= `UDPEC_RST_BYTE; // R17
                end
                else if (wr_len_any && wr_ep == 3'(e))
                begin
                    len_r[e] <= REG_WDATA_I; // R16
                end
            end
        end
    endgenerate

    // ****************************************************
    // read port
    // ****************************************************

    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic [2:0] rd_ep;

    always_comb
    begin
        rd_ep = ep_of(REG_ADDR_I);
        rdata_nxt = `UDPEC_RST_BYTE;
        if (REG_RD_I)
        begin
            if (REG_ADDR_I == `UDPEC_ADDR_PORT)
            begin
                rdata_nxt[`UDPEC_PORT_PD_DIS] = pd_dis_r;
                rdata_nxt[`UDPEC_PORT_DP] = dp_sync_r; // R2
                rdata_nxt[`UDPEC_PORT_DM] = dm_sync_r; // R2
                rdata_nxt[`UDPEC_PORT_LOW] = slow_r;
                rdata_nxt[`UDPEC_PORT_FLAG] = user_flag_r;
                rdata_nxt[`UDPEC_PORT_EN] = port_en_r;
            end
            else if (REG_ADDR_I == `UDPEC_ADDR_MODE)
            begin
                rdata_nxt = mode_r;
            end
            else if (rd_ep < 3'(EP_NUM))
            begin
                rdata_nxt = REG_ADDR_I[`UDPEC_LEN_BIT] ? len_r[rd_ep] : ctl_r[rd_ep];
            end
        end
    end

    // data stand only in the cycle after the read strobe
    always_ff @(posedge MCLK_I)
    begin
        if (SRST_I)
        begin
            rdata_r <= `UDPEC_RST_BYTE;
        end
        else
        begin
            rdata_r <= rdata_nxt;
        end
    end

    // ****************************************************
    // token answer to the serial engine
    // ****************************************************

    logic [2:0] tk_ep;
    logic [7:0] tk_ctl;
    logic tk_rx_en;
    logic tk_tx_en;
    logic tk_enabled;
    logic tk_tog;
    logic [1:0] tk_code;
    logic [7:0] tk_off;
    udpec_answer_t ans_r;
    udpec_answer_t ans_nxt;

    always_comb
    begin
        tk_ep = TOKEN_I.ep;
        tk_ctl = (tk_ep < 3'(EP_NUM)) ? ctl_r[tk_ep] : `UDPEC_RST_BYTE;
        tk_tog = TOKEN_I.is_in ? tk_ctl[`UDPEC_CTL_TTOG] : tk_ctl[`UDPEC_CTL_RTOG]; // R7 R8
        tk_code = TOKEN_I.is_in ? tk_ctl[`UDPEC_CTL_TRES_HI:`UDPEC_CTL_TRES_LO]
                                : tk_ctl[`UDPEC_CTL_RRES_HI:`UDPEC_CTL_RRES_LO]; // R11
        tk_rx_en = 1'b0;
        tk_tx_en = 1'b0;
        tk_off = `UDPEC_RST_BYTE;
        case (tk_ep)
            3'h0:
            begin
                tk_rx_en = 1'b1;
                tk_tx_en = 1'b1;
            end
            3'h1:
            begin
                tk_rx_en = mode_r[`UDPEC_MODE_EP1_RX]; // R18
                tk_tx_en = mode_r[`UDPEC_MODE_EP1_TX]; // R18
                tk_off = buf_off_of(tk_rx_en, tk_tx_en, mode_r[`UDPEC_MODE_EP1_BUF],
                    TOKEN_I.is_in, tk_tog); // R19
            end
            3'h2:
            begin
                tk_rx_en = EP23_MODE_I[`UDPEC_M23_EP2_RX];
                tk_tx_en = EP23_MODE_I[`UDPEC_M23_EP2_TX];
                tk_off = buf_off_of(tk_rx_en, tk_tx_en, EP23_MODE_I[`UDPEC_M23_EP2_BUF],
                    TOKEN_I.is_in, tk_tog);
            end
            3'h3:
            begin
                tk_rx_en = EP23_MODE_I[`UDPEC_M23_EP3_RX];
                tk_tx_en = EP23_MODE_I[`UDPEC_M23_EP3_TX];
                tk_off = buf_off_of(tk_rx_en, tk_tx_en, EP23_MODE_I[`UDPEC_M23_EP3_BUF],
                    TOKEN_I.is_in, tk_tog);
            end
            3'h4:
            begin
                tk_rx_en = mode_r[`UDPEC_MODE_EP4_RX]; // R20
                tk_tx_en = mode_r[`UDPEC_MODE_EP4_TX]; // R20
                // layout shared with endpoint 0 depends on the receive enable bit only
                if (TOKEN_I.is_in && tk_rx_en)
                begin
                    tk_off = `UDPEC_BUF_STEP2; // R21 R22
                end
                else
                begin
                    tk_off = `UDPEC_BUF_STEP; // R21 R22
                end
            end
            default:
            begin
                tk_rx_en = 1'b0;
                tk_tx_en = 1'b0;
            end
        endcase
        tk_enabled = port_en_r && (TOKEN_I.is_in ? tk_tx_en : tk_rx_en); // R5
        ans_nxt.valid = TOKEN_I.valid;
        ans_nxt.hs = tk_enabled ? hs_of(TOKEN_I.is_in, tk_code) : UDPEC_HS_NONE;
        ans_nxt.pid_odd = tk_tog; // R8
        ans_nxt.len = (tk_ep < 3'(EP_NUM)) ? len_r[tk_ep] : `UDPEC_RST_BYTE; // R16
        ans_nxt.buf_off = tk_off;
    end

    // a fresh answer each token; idle cycles show an all-zero answer
    always_ff @(posedge MCLK_I)
    begin
        if (SRST_I || !TOKEN_I.valid)
        begin
            ans_r <= '0;
        end
        else
        begin
            ans_r <= ans_nxt;
        end
    end

    // ****************************************************
    // outputs
    // ****************************************************

    assign REG_RDATA_O = rdata_r;
    assign ANSWER_O = ans_r;
    assign PULLDOWN_DIS_O = pd_dis_r; // R1
    assign SLOW_RATE_O = slow_r; // R3
    assign PHYS_PORT_EN_O = port_en_r; // R5
    assign EP14_MODE_O = mode_r;

endmodule

`default_nettype wire
